// *** oss_meter.sv ***
// Purpose: meter model reading the scaler's output terminals
// Assumes: terminals sampled on the control clock
// Notes: period in clock cycles, reading in mV or uA
`timescale 1ns/100ps
`default_nettype none
module oss_meter
(
  // Clock
  input wire logic i_clock,
  // Terminals under observation
  input wire logic i_pulse,
  input wire logic [13:0] i_level,
  input wire logic i_current_mode,
  // Readings
  output var integer o_period,
  output var integer o_reading
);
  int cnt = 0;
  logic prev = 1'b0;
  // Cycles between rising edges of the pulse terminal
  always @(posedge i_clock)
  begin
    prev <= i_pulse;
    if (i_pulse === 1'b1 && prev === 1'b0)
    begin
      o_period <= cnt + 1;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
  // Full level is 10 V or 20 mA
  assign o_reading = i_current_mode ? 2 * integer'(i_level) :
                     integer'(i_level);
endmodule : oss_meter
`default_nettype wire

// *** oss_output_scaler.sv ***
// Purpose: source select of pulse and analog outs, gain/offset scaling of analog outs
// Assumes: quantities come from logic on the same clock, no sync needed
// Notes: analog levels are 0.01 % of full scale, pulse is a square wave
`timescale 1ns/100ps
`default_nettype none
module oss_output_scaler
  import oss_pkg::*;
#(
  parameter logic [31:0] OUT_VOLT_FS = 32'h0000_2710  // Code 8 scale
)
(
  // Clock, reset and enable
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [5:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // Drive quantities
  input wire oss_meas_type i_meas,
  // Output terminals
  output logic o_pulse_freq_output,
  output logic [13:0] o_analog_out_first,
  output logic [13:0] o_analog_out_second,
  output logic o_ao1_current_mode,
  output logic o_ao2_current_mode
);

  // Percent of full scale, clamped to 0..100 %
  function automatic logic [13:0] ratio(input logic [31:0] n,
                                        input logic [31:0] d);
    logic [47:0] q;
    q = 48'h0;
    if (d != 32'h0)
    begin
      q = (48'(n) * 48'(OSS_FULL_I)) / 48'(d);
    end
    if (q > 48'(OSS_FULL))
    begin
      q = 48'(OSS_FULL);
    end
    return q[13:0];
  endfunction : ratio

  // Source code to standard percent
  function automatic logic [13:0] source_pct(input logic [4:0] code,
                                             input oss_meas_type m);
    logic [31:0] t;
    logic [31:0] fs;
    t = 32'h0;
    fs = 32'h0;
    case (code)
      5'h00: source_pct = ratio(32'(m.run_freq), 32'(m.max_freq));
      5'h01: source_pct = ratio(32'(m.set_freq), 32'(m.max_freq));
      5'h02: source_pct = ratio(32'(m.current),
                                32'(m.rated_current) << 1);
      5'h03:
      begin
        t = m.torque[15] ? 32'(-m.torque) : 32'(m.torque);
        source_pct = ratio(t, OSS_FS_TORQ);
      end
      5'h04: source_pct = ratio(32'(m.power),
                                32'(m.rated_power) << 1);
      5'h05:
      begin
        fs = (32'(m.rated_bus_volt) * 32'h0000_000c) / 32'h0000_000a;
        source_pct = ratio(32'(m.bus_volt), fs);
      end
      5'h06: source_pct = ratio(32'(m.speed), 32'(m.speed_at_max));
      5'h07: source_pct = ratio(32'(m.current), OSS_FS_AMPS);
      5'h08: source_pct = ratio(32'(m.out_volt), OUT_VOLT_FS);
      5'h09:
      begin
        t = 32'(signed'(m.torque)) + OSS_FS_TORQ;
        if (t[31])
        begin
          t = 32'h0;
        end
        source_pct = ratio(t, OSS_FS_TORQ << 1);
      end
      5'h0a:
      begin
        t = (m.pulse_in > OSS_PULSE_MIN) ?
            32'(m.pulse_in - OSS_PULSE_MIN) : 32'h0;
        source_pct = ratio(t, 32'(OSS_PIN_MAX - OSS_PULSE_MIN));
      end
      5'h0b: source_pct = ratio(32'(m.analog_in_first), OSS_FS_AIN);
      5'h0c: source_pct = ratio(32'(m.analog_in_second), OSS_FS_AIN);
      5'h0d: source_pct = ratio(32'(m.analog_in_third), OSS_FS_AIN);
      5'h0e: source_pct = ratio(32'(m.length), 32'(m.max_length));
      5'h0f: source_pct = ratio(32'(m.count), 32'(m.max_count));
      5'h10: source_pct = ratio(32'(m.comm_value), OSS_FS_COMM);
      default: source_pct = 14'h0;
    endcase
  endfunction : source_pct

  // Y = kX + b, clamped to the physical span
  function automatic logic [13:0] adjust(input logic [13:0] x,
                                         input logic signed [15:0] k,
                                         input logic signed [15:0] b);
    logic signed [31:0] y;
    y = (k * $signed({18'h0, x})) / OSS_GAIN_DIV;
    y = y + 32'(b) * OSS_OFS_MUL;
    if (y < 0)
    begin
      y = 0;
    end
    else if (y > 32'(OSS_FULL))
    begin
      y = 32'(OSS_FULL);
    end
    return y[13:0];
  endfunction : adjust

  // Signed range clamp for written settings
  function automatic logic [15:0] clamp_s(input logic [15:0] v,
                                          input logic signed [15:0] lim);
    if ($signed(v) > lim)
    begin
      return lim;
    end
    if ($signed(v) < -lim)
    begin
      return -lim;
    end
    return v;
  endfunction : clamp_s

  // Merge written byte lanes into a 16-bit setting
  function automatic logic [15:0] lanes(input logic [15:0] old,
                                        input logic [3:0] sel,
                                        input logic [31:0] dat);
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : lanes

  // Settings and bus state
  logic [4:0] sel_pulse_q, sel_pulse_d;
  logic [4:0] sel_ao1_q, sel_ao1_d;
  logic [4:0] sel_ao2_q, sel_ao2_d;
  logic [15:0] max_pulse_q, max_pulse_d;
  logic [15:0] ofs1_q, ofs1_d, gain1_q, gain1_d;
  logic [15:0] ofs2_q, ofs2_d, gain2_q, gain2_d;
  logic [1:0] mode_q, mode_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [15:0] pfreq_q, pfreq_d;
  logic [15:0] tmp;
  logic wr;

  // Register writes and read mux
  always_comb
  begin
    sel_pulse_d = sel_pulse_q;
    sel_ao1_d = sel_ao1_q;
    sel_ao2_d = sel_ao2_q;
    max_pulse_d = max_pulse_q;
    ofs1_d = ofs1_q;
    gain1_d = gain1_q;
    ofs2_d = ofs2_q;
    gain2_d = gain2_q;
    mode_d = mode_q;
    rdat_d = 32'h0;
    tmp = 16'h0;
    wr = i_wb_cyc && i_wb_stb && !ack_q && i_wb_we;
    ack_d = i_wb_cyc && i_wb_stb && !ack_q;
    if (wr && i_wb_sel[0])
    begin
      case (i_wb_adr)
        OSS_OFF_SEL_PULSE: sel_pulse_d = i_wb_dat[4:0];
        OSS_OFF_SEL_AO1: sel_ao1_d = i_wb_dat[4:0];
        OSS_OFF_SEL_AO2: sel_ao2_d = i_wb_dat[4:0];
        OSS_OFF_MODE: mode_d = i_wb_dat[1:0];
        default: mode_d = mode_q;
      endcase
    end
    if (wr)
    begin
      case (i_wb_adr)
        OSS_OFF_MAX_PULSE:
        begin
          tmp = lanes(max_pulse_q, i_wb_sel, i_wb_dat);
          if (tmp < OSS_PULSE_MIN)
          begin
            tmp = OSS_PULSE_MIN;
          end
          else if (tmp > OSS_PULSE_MAX)
          begin
            tmp = OSS_PULSE_MAX;
          end
          max_pulse_d = tmp;
        end
        OSS_OFF_AO1_OFS: ofs1_d = clamp_s(lanes(ofs1_q, i_wb_sel, i_wb_dat),
                                          OSS_OFS_LIM);
        OSS_OFF_AO1_GAIN: gain1_d = clamp_s(lanes(gain1_q, i_wb_sel,
                                            i_wb_dat), OSS_GAIN_LIM);
        OSS_OFF_AO2_OFS: ofs2_d = clamp_s(lanes(ofs2_q, i_wb_sel, i_wb_dat),
                                          OSS_OFS_LIM);
        OSS_OFF_AO2_GAIN: gain2_d = clamp_s(lanes(gain2_q, i_wb_sel,
                                            i_wb_dat), OSS_GAIN_LIM);
        default: tmp = 16'h0;
      endcase
    end
    case (i_wb_adr)
      OSS_OFF_SEL_PULSE: rdat_d = 32'(sel_pulse_q);
      OSS_OFF_SEL_AO1: rdat_d = 32'(sel_ao1_q);
      OSS_OFF_SEL_AO2: rdat_d = 32'(sel_ao2_q);
      OSS_OFF_MAX_PULSE: rdat_d = 32'(max_pulse_q);
      OSS_OFF_AO1_OFS: rdat_d = 32'(ofs1_q);
      OSS_OFF_AO1_GAIN: rdat_d = 32'(gain1_q);
      OSS_OFF_AO2_OFS: rdat_d = 32'(ofs2_q);
      OSS_OFF_AO2_GAIN: rdat_d = 32'(gain2_q);
      OSS_OFF_AO1_LVL: rdat_d = 32'(o_analog_out_first);
      OSS_OFF_AO2_LVL: rdat_d = 32'(o_analog_out_second);
      OSS_OFF_PULSE_F: rdat_d = 32'(pfreq_q);
      OSS_OFF_MODE: rdat_d = 32'(mode_q);
      default: rdat_d = 32'h0;
    endcase
  end

  // Output scaling pipeline
  logic [13:0] pct0_q, pct0_d, pct1_q, pct1_d, pct2_q, pct2_d;
  logic [13:0] lvl1_d, lvl2_d;
  logic [31:0] span;

  // Standard percent, adjusted levels and pulse frequency
  always_comb
  begin
    pct0_d = source_pct(sel_pulse_q, i_meas);
    pct1_d = source_pct(sel_ao1_q, i_meas);
    pct2_d = source_pct(sel_ao2_q, i_meas);
    lvl1_d = adjust(pct1_q, gain1_q, ofs1_q);
    lvl2_d = adjust(pct2_q, gain2_q, ofs2_q);
    // New maximum takes hold on the same edge, so no overshoot after a write
    span = (32'(pct0_q) * 32'(max_pulse_d - OSS_PULSE_MIN)) /
           32'(OSS_FULL_I);
    pfreq_d = OSS_PULSE_MIN + span[15:0];
  end

  // Pulse synthesis
  logic [21:0] acc_q, acc_d;
  logic pulse_q, pulse_d;

  // Half period accumulator toggles the terminal
  always_comb
  begin
    acc_d = acc_q + 22'(pfreq_q);
    pulse_d = pulse_q;
    if (acc_d >= OSS_PULSE_MOD)
    begin
      acc_d = acc_d - OSS_PULSE_MOD;
      pulse_d = !pulse_q;
    end
  end

  // State registers
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sel_pulse_q <= OSS_RST_SEL_PULSE;
      sel_ao1_q <= OSS_RST_SEL_AO1;
      sel_ao2_q <= OSS_RST_SEL_AO2;
      max_pulse_q <= OSS_PULSE_MAX;
      ofs1_q <= 16'h0;
      gain1_q <= OSS_GAIN_ONE;
      ofs2_q <= 16'h0;
      gain2_q <= OSS_GAIN_ONE;
      mode_q <= 2'h0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
      pct0_q <= 14'h0;
      pct1_q <= 14'h0;
      pct2_q <= 14'h0;
      o_analog_out_first <= 14'h0;
      o_analog_out_second <= 14'h0;
      pfreq_q <= OSS_PULSE_MIN;
      acc_q <= 22'h0;
      pulse_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      sel_pulse_q <= sel_pulse_d;
      sel_ao1_q <= sel_ao1_d;
      sel_ao2_q <= sel_ao2_d;
      max_pulse_q <= max_pulse_d;
      ofs1_q <= ofs1_d;
      gain1_q <= gain1_d;
      ofs2_q <= ofs2_d;
      gain2_q <= gain2_d;
      mode_q <= mode_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      pct0_q <= pct0_d;
      pct1_q <= pct1_d;
      pct2_q <= pct2_d;
      o_analog_out_first <= lvl1_d;
      o_analog_out_second <= lvl2_d;
      pfreq_q <= pfreq_d;
      acc_q <= acc_d;
      pulse_q <= pulse_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_pulse_freq_output = pulse_q;
  assign o_ao1_current_mode = mode_q[0];
  assign o_ao2_current_mode = mode_q[1];

  // Checks
  AST_MAXP_RANGE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    max_pulse_q >= OSS_PULSE_MIN && max_pulse_q <= OSS_PULSE_MAX)
    else $error("max pulse setting out of range");
  AST_PULSE_SPAN: assert property (@(posedge i_clock) disable iff (!i_resetn)
    pfreq_q >= OSS_PULSE_MIN && pfreq_q <= max_pulse_q)
    else $error("pulse frequency outside span");
  AST_AO_CLAMP: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_analog_out_first <= OSS_FULL && o_analog_out_second <= OSS_FULL)
    else $error("analog level above full scale");
  AST_GAIN_RANGE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $signed(gain1_q) <= OSS_GAIN_LIM && $signed(gain1_q) >= -OSS_GAIN_LIM)
    else $error("gain out of range");
  AST_OFS_RANGE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $signed(ofs2_q) <= OSS_OFS_LIM && $signed(ofs2_q) >= -OSS_OFS_LIM)
    else $error("offset out of range");
  AST_UNITY: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && gain1_q == OSS_GAIN_ONE && ofs1_q == 16'h0
    |=> o_analog_out_first == $past(pct1_q))
    else $error("unity setting changes the level");
  AST_TORQ_MID: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && sel_ao2_q == 5'h09 && i_meas.torque == 16'sh0
    |=> pct2_q == 14'h1388)
    else $error("zero torque not at mid scale");
  AST_ACK_PULSE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && o_wb_ack |=> !o_wb_ack)
    else $error("ack held more than one cycle");
  AST_ACK_REQ: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered");
endmodule : oss_output_scaler
`default_nettype wire

// *** oss_pkg.sv ***
// Purpose: constants, register map and carriers of the output scaler
// Assumes: 50 MHz control clock, classic Wishbone register access
// Notes: percent values are in 0.01 % steps, 10000 meaning full scale
// Notes on behaviour
// - Pulse spans 0.01 kHz to set maximum
// - Maximum pulse 0.01-50.00 kHz, resets 50.00
// - Three selectors; resets 0, 0 and 1
// - Analog full scale is 10 V or 20 mA
// - Codes 0,1,6 scale to maximum frequency
// - Code 2 twice rated, 7 1000.0 A
// - Code 3 absolute torque, twice rated
// - Code 4 power, twice rated full
// - Code 5 voltage, 1.2 times rated bus
// - Code 9 signed torque, -200..+200 %
// - Code 10 pulse input, 11-13 analog inputs
// - Codes 14,15 length/count, 16 to 32767
// - Actual equals gain times standard plus offset
// - Offset -100..100 %, resets zero
// - Standard output is the unadjusted value
package oss_pkg;
  // Register offsets (byte addresses)
  localparam logic [5:0] OSS_OFF_SEL_PULSE = 6'h00;
  localparam logic [5:0] OSS_OFF_SEL_AO1 = 6'h04;
  localparam logic [5:0] OSS_OFF_SEL_AO2 = 6'h08;
  localparam logic [5:0] OSS_OFF_MAX_PULSE = 6'h0c;
  localparam logic [5:0] OSS_OFF_AO1_OFS = 6'h10;
  localparam logic [5:0] OSS_OFF_AO1_GAIN = 6'h14;
  localparam logic [5:0] OSS_OFF_AO2_OFS = 6'h18;
  localparam logic [5:0] OSS_OFF_AO2_GAIN = 6'h1c;
  localparam logic [5:0] OSS_OFF_AO1_LVL = 6'h20;
  localparam logic [5:0] OSS_OFF_AO2_LVL = 6'h24;
  localparam logic [5:0] OSS_OFF_PULSE_F = 6'h28;
  localparam logic [5:0] OSS_OFF_MODE = 6'h2c;
  // Reset values and ranges
  localparam logic [4:0] OSS_RST_SEL_PULSE = 5'h00;
  localparam logic [4:0] OSS_RST_SEL_AO1 = 5'h00;
  localparam logic [4:0] OSS_RST_SEL_AO2 = 5'h01;
  localparam logic [15:0] OSS_PULSE_MIN = 16'h0001;   // 0.01 kHz
  localparam logic [15:0] OSS_PULSE_MAX = 16'h1388;   // 50.00 kHz
  localparam logic [15:0] OSS_PIN_MAX = 16'h2710;     // 100.00 kHz
  localparam logic signed [15:0] OSS_GAIN_LIM = 16'sh03e8;  // 10.00
  localparam logic signed [15:0] OSS_GAIN_ONE = 16'sh0064;  // 1.00
  localparam logic signed [15:0] OSS_OFS_LIM = 16'sh03e8;   // 100.0 %
  localparam int OSS_GAIN_DIV = 100;
  localparam int OSS_OFS_MUL = 10;
  // Full scale of the percent domain
  localparam logic [13:0] OSS_FULL = 14'h2710;
  localparam int OSS_FULL_I = 10000;
  // Fixed full scales of source quantities
  localparam logic [31:0] OSS_FS_AMPS = 32'h0000_2710;  // 1000.0 A
  localparam logic [31:0] OSS_FS_AIN = 32'h0000_03e8;   // 10.00 V
  localparam logic [31:0] OSS_FS_COMM = 32'h0000_7fff;  // 32767
  localparam logic [31:0] OSS_FS_TORQ = 32'h0000_07d0;  // 200.0 %
  // Pulse synthesis timing
  localparam int OSS_CLK_HZ = 50_000_000;
  localparam int OSS_PULSE_UNIT_HZ = 10;
  localparam int OSS_PULSE_MOD_I = OSS_CLK_HZ / (2 * OSS_PULSE_UNIT_HZ);
  localparam logic [21:0] OSS_PULSE_MOD = 22'(OSS_PULSE_MOD_I);
  // Internal drive quantities, all from the control clock domain
  typedef struct packed {
    logic [15:0] run_freq;      // 0.01 Hz
    logic [15:0] set_freq;
    logic [15:0] max_freq;
    logic [15:0] speed;         // rpm
    logic [15:0] speed_at_max;
    logic [15:0] current;       // 0.1 A
    logic [15:0] rated_current;
    logic signed [15:0] torque; // 0.1 % of rated
    logic [15:0] power;         // 0.1 kW
    logic [15:0] rated_power;
    logic [15:0] bus_volt;      // 0.1 V
    logic [15:0] rated_bus_volt;
    logic [15:0] out_volt;      // 0.1 V
    logic [15:0] pulse_in;      // 0.01 kHz
    logic [15:0] analog_in_first;   // 0.01 V
    logic [15:0] analog_in_second;
    logic [15:0] analog_in_third;
    logic [15:0] length;
    logic [15:0] max_length;
    logic [15:0] count;
    logic [15:0] max_count;
    logic [15:0] comm_value;
  } oss_meas_type;
endpackage : oss_pkg

// *** tb_top.sv ***
// Purpose: self-checking bench of the output scaler
// Assumes: one-cycle Wishbone answer, 50 MHz clock
// Notes: read data expectations queued by driver, checked by monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import oss_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  oss_meas_type meas = '0;
  logic ack, pulse, mode1, mode2;
  logic [31:0] rdat;
  logic [13:0] lvl1, lvl2;
  integer period, reading;
  int errors = 0, checked = 0, cycles = 0;
  int code, p, pct, i, k, b, e;
  integer seed = 32'h79ca;
  logic [31:0] expq[$];

  always #10 clk = ~clk;

  oss_output_scaler dut (.i_clock(clk), .i_resetn(rstn), .i_clk_en(1'b1),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_meas(meas), .o_pulse_freq_output(pulse), .o_analog_out_first(lvl1),
    .o_analog_out_second(lvl2), .o_ao1_current_mode(mode1),
    .o_ao2_current_mode(mode2));
  oss_meter meter (.i_clock(clk), .i_pulse(pulse), .i_level(lvl1),
    .i_current_mode(mode1), .o_period(period), .o_reading(reading));

  task automatic report(input string msg);
    errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : report
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
      report($sformatf("read %h expected %h", got, exp));
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
      report($sformatf("mode %b expected %b", got, exp));
  endtask : cmp_bit
  task automatic cmp_int(input integer got, input int exp, input int tol);
    checked++;
    if ($isunknown(got) || got > exp + tol || got < exp - tol)
      report($sformatf("meter %0d expected %0d", got, exp));
  endtask : cmp_int
  task automatic conclude;
    $display("Counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [5:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
      report("no ack");
  endtask : wb
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    expq.push_back(x);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  // Quantity giving p percent of full scale for a source code
  function automatic oss_meas_type mk(input int c, input int q);
    oss_meas_type m;
    m = '0;
    m.max_freq = 16'h2710;
    m.speed_at_max = 16'h03e8;
    m.rated_current = 16'h03e8;
    m.rated_power = 16'h03e8;
    m.rated_bus_volt = 16'h03e8;
    m.max_length = 16'h03e8;
    m.max_count = 16'h03e8;
    m.torque = 16'(-2000);
    m.pulse_in = 16'h0001;
    case (c)
      0: m.run_freq = 16'(q * 100);
      1: m.set_freq = 16'(q * 100);
      2: m.current = 16'(q * 20);
      3: m.torque = 16'(-q * 20);
      4: m.power = 16'(q * 20);
      5: m.bus_volt = 16'(q * 12);
      6: m.speed = 16'(q * 10);
      7: m.current = 16'(q * 100);
      8: m.out_volt = 16'(q * 100);
      9: m.torque = 16'(q * 40 - 2000);
      10: m.pulse_in = 16'(1 + q * 9999 / 100);
      11: m.analog_in_first = 16'(q * 10);
      12: m.analog_in_second = 16'(q * 10);
      13: m.analog_in_third = 16'(q * 10);
      14: m.length = 16'(q * 10);
      15: m.count = 16'(q * 10);
      16: m.comm_value = 16'(q * 32767 / 100);
      default: m.run_freq = 16'h0;
    endcase
    return m;
  endfunction : mk

  // Read answers checked against the oldest expectation
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0)
    begin
      if (expq.size() == 0)
        report("unexpected read");
      else
        cmp_word(rdat, expq.pop_front());
    end
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      report("timeout");
      conclude();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(OSS_OFF_SEL_PULSE, 32'h0);
    rd(OSS_OFF_SEL_AO1, 32'h0);
    rd(OSS_OFF_SEL_AO2, 32'h1);
    rd(OSS_OFF_MAX_PULSE, 32'h1388);
    rd(OSS_OFF_AO1_GAIN, 32'h64);
    rd(OSS_OFF_AO2_GAIN, 32'h64);
    rd(OSS_OFF_AO1_OFS, 32'h0);
    rd(OSS_OFF_AO2_OFS, 32'h0);
    rd(6'h30, 32'h0);
    $display("test defaults done");
    wb(1'b1, OSS_OFF_SEL_AO1, 32'h5, 4'h0);
    rd(OSS_OFF_SEL_AO1, 32'h0);
    wr(OSS_OFF_MAX_PULSE, 32'h0);
    rd(OSS_OFF_MAX_PULSE, 32'h1);
    wr(OSS_OFF_MAX_PULSE, 32'hea60);
    rd(OSS_OFF_MAX_PULSE, 32'h1388);
    wr(OSS_OFF_AO2_GAIN, 32'hf830);
    rd(OSS_OFF_AO2_GAIN, 32'hfc18);
    wr(OSS_OFF_AO2_OFS, 32'h07d0);
    rd(OSS_OFF_AO2_OFS, 32'h03e8);
    wr(OSS_OFF_AO2_GAIN, 32'h64);
    wr(OSS_OFF_AO2_OFS, 32'h0);
    $display("test limits done");
    for (code = 0; code < 18; code++)
    begin
      p = $unsigned($random(seed)) % 101;
      if (code == 10 || code == 16)
        p = 100 * (p % 2);
      pct = (code > 16) ? 0 : p * 100;
      wr(OSS_OFF_SEL_PULSE, 32'(code));
      wr(OSS_OFF_SEL_AO1, 32'(code));
      wr(OSS_OFF_SEL_AO2, 32'(code));
      meas <= mk(code, p);
      repeat (3) @(posedge clk);
      rd(OSS_OFF_AO1_LVL, 32'(pct));
      rd(OSS_OFF_AO2_LVL, 32'(pct));
      rd(OSS_OFF_PULSE_F, 32'(1 + pct * 4999 / 10000));
    end
    wr(OSS_OFF_SEL_AO2, 32'h9);
    meas <= mk(9, 50);
    repeat (3) @(posedge clk);
    rd(OSS_OFF_AO2_LVL, 32'h1388);
    $display("test sources done");
    wr(OSS_OFF_SEL_AO1, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      k = (i < 2) ? -50 : $random(seed) % 1001;
      b = (i < 2) ? 800 : $random(seed) % 1001;
      p = (i < 2) ? i * 100 : $unsigned($random(seed)) % 101;
      e = k * p + b * 10;
      e = (e < 0) ? 0 : (e > 10000) ? 10000 : e;
      wr(OSS_OFF_AO1_GAIN, {16'h0, 16'(k)});
      wr(OSS_OFF_AO1_OFS, {16'h0, 16'(b)});
      wr(OSS_OFF_MODE, {30'h0, i[0], i[0]});
      meas <= mk(0, p);
      repeat (3) @(posedge clk);
      rd(OSS_OFF_AO1_LVL, 32'(e));
      cmp_int(reading, i[0] ? 2 * e : e, 0);
      cmp_bit(mode2, i[0]);
    end
    $display("test gain done");
    wr(OSS_OFF_SEL_PULSE, 32'h0);
    meas <= mk(0, 100);
    wr(OSS_OFF_MAX_PULSE, 32'h1388);
    repeat (4000) @(posedge clk);
    cmp_int(period, 1000, 1);
    wr(OSS_OFF_MAX_PULSE, 32'h09c4);
    repeat (8000) @(posedge clk);
    cmp_int(period, 2000, 1);
    rd(OSS_OFF_PULSE_F, 32'h09c4);
    $display("test pulse done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(OSS_OFF_SEL_AO2, 32'h1);
    rd(OSS_OFF_MAX_PULSE, 32'h1388);
    rd(OSS_OFF_AO1_GAIN, 32'h64);
    rd(OSS_OFF_AO1_OFS, 32'h0);
    $display("test reset done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
